// File: bench/ssp_link_sva.sv
// ssp_link_sva: wire-level checks between the master and slave ends
`timescale 1ns/1ps
`default_nettype none
module ssp_link_sva (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic serial_clock_pin,
	input wire logic serial_out_pin_m,
	input wire logic serial_out_oe_n_s,
	input wire logic slave_select_n,
	input wire logic two_wire_data_pin,
	input wire logic two_wire_clock_pin
);
	logic [5:0] tog_q;
	logic sck_q;
	logic [1:0] up_q;
	logic [5:0] tot;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// clock toggles in this select window, the one landing now included
	assign tot = tog_q + {5'h00, serial_clock_pin != sck_q};
	// window count clears while deselected so each frame starts at zero
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tog_q <= 6'h00;
			sck_q <= 1'b0;
		end else begin
			tog_q <= slave_select_n ? 6'h00 : tot;
			sck_q <= serial_clock_pin;
		end
	end
	// idle level lands one edge after reset, so clock checks wait a little
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			up_q <= 2'h0;
		end else if (up_q != 2'h3) begin
			up_q <= up_q + 2'h1;
		end
	end
	sel_drive_a: assert property (slave_select_n [*5] |-> serial_out_oe_n_s)
		else $error("slave output enabled while deselected");
	sel_enable_a: assert property ($fell(slave_select_n) |-> ##[1:4] !serial_out_oe_n_s)
		else $error("slave output not enabled after select");
	clk_halt_a: assert property (up_q == 2'h3 && slave_select_n && $past(slave_select_n)
		|-> $stable(serial_clock_pin)) else $error("serial clock moved outside a frame");
	half_min_a: assert property (up_q == 2'h3 && $changed(serial_clock_pin)
		|=> $stable(serial_clock_pin) [*4]) else $error("serial clock half period too short");
	first_edge_a: assert property ($fell(slave_select_n) |-> ##[1:20] $changed(serial_clock_pin))
		else $error("no clock edge after select");
	byte_bits_a: assert property ($rose(slave_select_n) |-> tot[3:0] == 4'h0 && tot != 6'h00)
		else $error("frame ended off a byte boundary");
	out_edge_a: assert property ($changed(serial_out_pin_m) && !slave_select_n && tot[3:0] != 4'h0
		|-> serial_clock_pin != $past(serial_clock_pin, 2) && !tot[0]) else $error("data out moved off its edge");
	wire_excl_a: assert property ($changed(two_wire_data_pin) || $changed(two_wire_clock_pin)
		|-> slave_select_n) else $error("two-wire lines moved during a frame");
endmodule
`default_nettype wire

// File: bench/test_sync_serial_port_spi_brg.sv
// test_sync_serial_port_spi_brg: master and slave ends joined, driven from user side
`timescale 1ns/1ps
`default_nettype none
module test_sync_serial_port_spi_brg;
	import ssp_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic pol = 1'b0;
	logic [7:0] reload = 8'h04;
	logic tw_mode = 1'b0;
	logic [7:0] m_tx = 8'h00;
	logic m_valid = 1'b0;
	logic m_rdy;
	logic ctrl_wr = 1'b0;
	logic [7:0] ctrl_wdata = 8'h00;
	logic [7:0] ctrl2;
	logic [7:0] m_rx;
	logic m_rx_valid;
	logic rx_ready = 1'b0;
	logic done;
	logic busy;
	logic [7:0] s_tx = 8'h00;
	logic [7:0] s_rx;
	logic s_rx_valid;
	logic [7:0] s_q[$];
	int done_n = 0;
	int fail_count = 0;
	int num_checks = 0;
	ssp_link_if link();
	ssp_master ssp_master_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clock_idle_polarity_i(pol),
		.rate_reload_reg_i(reload), .two_wire_mode_i(tw_mode), .tx_data_i(m_tx), .tx_valid_i(m_valid),
		.tx_ready_o(m_rdy), .ctrl_wr_i(ctrl_wr), .ctrl_wdata_i(ctrl_wdata), .serial_control_two_o(ctrl2),
		.rx_data_o(m_rx), .rx_valid_o(m_rx_valid), .rx_ready_i(rx_ready), .serial_done_flag_o(done),
		.busy_o(busy), .link(link.master));
	// slave keeps its load request up so it reloads at every byte end; sole slave on its own select
	ssp_slave ssp_slave_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clock_idle_polarity_i(pol),
		.tx_data_i(s_tx), .tx_load_i(1'b1), .rx_data_o(s_rx), .rx_valid_o(s_rx_valid), .link(link.slave));
	ssp_link_sva ssp_link_sva_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.serial_clock_pin(link.serial_clock_pin), .serial_out_pin_m(link.serial_out_pin_m),
		.serial_out_oe_n_s(link.serial_out_oe_n_s), .slave_select_n(link.slave_select_n),
		.two_wire_data_pin(link.two_wire_data_pin), .two_wire_clock_pin(link.two_wire_clock_pin));
	always #5 core_clk_i = ~core_clk_i;
	// done and slave bytes are one-cycle pulses, so catch them here
	always @(posedge core_clk_i) begin
		if (done === 1'b1) done_n++;
		if (s_rx_valid === 1'b1) s_q.push_back(s_rx);
	end
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		num_checks++;
		if (s !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
			fail_count++;
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic hang;
		fail_count++;
		conclude();
	endtask
	task automatic do_reset;
		rst_n_i = 1'b0;
		tick(5);
		rst_n_i = 1'b1;
		tick(1);
	endtask
	// offer a byte; valid stays up afterwards so a next byte follows at once
	task automatic send(input logic [7:0] d);
		int k;
		k = 0;
		m_tx = d;
		m_valid = 1'b1;
		while (m_rdy !== 1'b1) begin
			tick(1);
			k++;
			if (k > 400) hang();
		end
		tick(1);
		chk("tx_ready_busy", 8'h00, {7'h00, m_rdy});
	endtask
	// cycles between the first two clock edges of a byte
	task automatic half(input logic [7:0] exp);
		logic s;
		int k;
		for (int e = 0; e < 2; e++) begin
			k = 0;
			s = link.serial_clock_pin;
			while (link.serial_clock_pin === s) begin
				tick(1);
				k++;
				if (k > 50) hang();
			end
		end
		chk("half_period", exp, k[7:0]);
	endtask
	initial begin
		logic [1:0] tw_exp [3];
		int k;
		int base;
		tw_exp = '{2'h0, 2'h1, 2'h3};
		do_reset();
		chk("ctrl2_reset", SSP_CTRL2_RST, ctrl2);
		// two passes, other polarity and rate each; reset between so idle level is clean
		for (int p = 0; p < 2; p++) begin
			pol = p[0];
			reload = 8'h04 + 8'(p * 2); // kept above 0x02
			s_tx = 8'h3c ^ 8'(p);
			do_reset();
			base = done_n;
			send(8'ha5 ^ 8'(p));
			half(8'(SSP_HALF_MULT) * (reload + 8'h01));
			send(8'h5a);
			m_valid = 1'b0;
			k = 0;
			while (done_n < base + 2) begin
				tick(1);
				k++;
				if (k > 800) hang();
			end
			tick(2);
			// receiver stalled all along: both bytes must wait in the buffer
			chk("m_rx_first", s_tx, m_rx);
			rx_ready = 1'b1;
			tick(1);
			chk("m_rx_second", s_tx, m_rx);
			tick(1);
			rx_ready = 1'b0;
			chk("m_rx_empty", 8'h00, {7'h00, m_rx_valid});
			chk("s_rx_count", 8'h02, 8'(s_q.size()));
			chk("s_rx_first", 8'ha5 ^ 8'(p), s_q.pop_front());
			chk("s_rx_second", 8'h5a, s_q.pop_front());
		end
		tw_mode = 1'b1;
		tick(1);
		chk("tw_tx_refused", 8'h00, {7'h00, m_rdy});
		// start, restart, stop in turn; a second request lands while the first is still pending
		for (int b = 0; b < 3; b++) begin
			ctrl_wdata = 8'h01 << b;
			ctrl_wr = 1'b1;
			tick(1);
			if (b == 0) begin
				ctrl_wdata = 8'h02;
				tick(1);
			end
			ctrl_wr = 1'b0;
			tick(1);
			if (b == 0) chk("busy_request", 8'h01, ctrl2);
			k = 0;
			while (busy === 1'b1 || ctrl2 !== 8'h00) begin
				tick(1);
				k++;
				if (k > 100) hang();
			end
			chk("tw_lines", {6'h00, tw_exp[b]}, {6'h00, link.two_wire_data_pin, link.two_wire_clock_pin});
		end
		conclude();
	end
endmodule
`default_nettype wire

// File: hw/ssp_link_if.sv
// ssp_link_if: serial wires between the master end and the slave end
`timescale 1ns/1ps
`default_nettype none
interface ssp_link_if;
	logic serial_clock_pin;
	logic serial_out_pin_m;
	logic serial_out_pin_s;
	logic serial_out_oe_n_s;
	logic slave_select_n;
	logic two_wire_data_pin;
	logic two_wire_clock_pin;
	// slave output only reaches the wire when enabled, otherwise the line floats high
	logic serial_in_pin_m;
	assign serial_in_pin_m = serial_out_oe_n_s ? 1'b1 : serial_out_pin_s;
	modport master (
		output serial_clock_pin,
		output serial_out_pin_m,
		input serial_in_pin_m,
		output slave_select_n,
		output two_wire_data_pin,
		output two_wire_clock_pin
	);
	modport slave (
		input serial_clock_pin,
		input serial_out_pin_m,
		output serial_out_pin_s,
		output serial_out_oe_n_s,
		input slave_select_n
	);
endinterface
`default_nettype wire

// File: hw/ssp_master.sv
// ssp_master: spi master with rate_counter, two-wire sequence requests, two-entry buffer
`timescale 1ns/1ps
`default_nettype none
module ssp_master
	import ssp_pkg::*;
#(
	parameter int DATA_W = SSP_DATA_W
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic clock_idle_polarity_i,
	input wire logic [7:0] rate_reload_reg_i,
	input wire logic two_wire_mode_i,
	input wire logic [DATA_W-1:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	input wire logic ctrl_wr_i,
	input wire logic [7:0] ctrl_wdata_i,
	output logic [7:0] serial_control_two_o,
	output logic [DATA_W-1:0] rx_data_o,
	output logic rx_valid_o,
	input wire logic rx_ready_i,
	output logic serial_done_flag_o,
	output logic busy_o,
	ssp_link_if.master link
);
	ssp_state_t state_q;
	ssp_seq_t seq_q;
	logic [7:0] cnt_q;
	logic [DATA_W-1:0] shift_q;
	logic [SSP_BIT_CNT_W-1:0] bit_q;
	logic phase_q;
	logic pre_q;
	logic samp_q;
	logic sck_q;
	logic ss_n_q;
	logic sda_q;
	logic scl_q;
	logic seq_ph_q;
	logic [7:0] ctrl_q;
	logic in_s1_q, in_s2_q;
	logic tick;
	logic tx_go;
	logic idle;
	// two-entry receive buffer so a stalled consumer loses no byte
	logic [DATA_W-1:0] buf_q [2];
	logic wr_ptr_q, rd_ptr_q;
	logic [1:0] buf_cnt_q;
	logic buf_push;
	logic buf_pop;
	logic buf_full;

	assign idle = (state_q == SSP_IDLE);
	assign buf_full = (buf_cnt_q == 2'd2);
	// refuse writes while busy or while no room for the returning byte
	// clock must rest at its idle level first, or the slave would see a false edge after reset
	assign tx_ready_o = idle && !buf_full && !two_wire_mode_i && (ctrl_q[SSP_STOP_BIT:SSP_START_BIT] == 3'b000)
		&& (sck_q == clock_idle_polarity_i);
	assign tx_go = tx_valid_i && tx_ready_o;
	// rate_counter rollover marks one half period
	assign tick = (cnt_q == 8'h00) && pre_q;
	assign busy_o = !idle;
	assign serial_control_two_o = ctrl_q;
	assign rx_valid_o = (buf_cnt_q != 2'd0);
	assign rx_data_o = buf_q[rd_ptr_q];
	assign buf_pop = rx_valid_o && rx_ready_i;

	// input pin crosses from the slave, two flops before use
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			in_s1_q <= 1'b0;
			in_s2_q <= 1'b0;
		end else begin
			in_s1_q <= link.serial_in_pin_m;
			in_s2_q <= in_s1_q;
		end
	end

	// rate_counter: loads on start, reloads each half period, reloaded every clock while idle or done
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= SSP_RELOAD_RST;
			pre_q <= 1'b0;
		end else if (tx_go || idle || state_q == SSP_DONE) begin
			cnt_q <= rate_reload_reg_i;
			pre_q <= 1'b0;
		end else begin
			// counts on every second clock, so two rollovers span 4 * (reload + 1) clocks
			pre_q <= ~pre_q;
			if (tick) begin
				cnt_q <= rate_reload_reg_i;
			end else if (pre_q) begin
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end

	// sequence request bits: set only when idle, cleared by hardware when done
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q <= SSP_CTRL2_RST;
		end else if (state_q == SSP_DONE && seq_q != SSP_SEQ_NONE) begin
			ctrl_q[SSP_STOP_BIT:SSP_START_BIT] <= 3'b000;
		end else if (ctrl_wr_i && idle && two_wire_mode_i && ctrl_q[SSP_STOP_BIT:SSP_START_BIT] == 3'b000) begin
			ctrl_q <= ctrl_wdata_i;
		end else if (ctrl_wr_i) begin
			ctrl_q[7:3] <= ctrl_wdata_i[7:3];
		end
	end

	// main sequencer
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= SSP_IDLE;
			seq_q <= SSP_SEQ_NONE;
			shift_q <= '0;
			bit_q <= '0;
			phase_q <= 1'b0;
			sck_q <= 1'b0;
			samp_q <= 1'b0;
			ss_n_q <= 1'b1;
			sda_q <= 1'b1;
			scl_q <= 1'b1;
			seq_ph_q <= 1'b0;
		end else begin
			case (state_q)
				SSP_IDLE: begin
					sck_q <= clock_idle_polarity_i;
					if (tx_go) begin
						shift_q <= tx_data_i;
						bit_q <= '0;
						phase_q <= 1'b0;
						ss_n_q <= 1'b0;
						state_q <= SSP_SHIFT;
					end else if (two_wire_mode_i && ctrl_q[SSP_START_BIT]) begin
						seq_q <= SSP_SEQ_START;
						seq_ph_q <= 1'b0;
						state_q <= SSP_SEQ;
					end else if (two_wire_mode_i && ctrl_q[SSP_RESTART_BIT]) begin
						seq_q <= SSP_SEQ_RESTART;
						seq_ph_q <= 1'b0;
						state_q <= SSP_SEQ;
					end else if (two_wire_mode_i && ctrl_q[SSP_STOP_BIT]) begin
						seq_q <= SSP_SEQ_STOP;
						seq_ph_q <= 1'b0;
						state_q <= SSP_SEQ;
					end
				end
				SSP_SHIFT: begin
					if (tick) begin
						sck_q <= ~sck_q;
						phase_q <= ~phase_q;
						if (!phase_q) begin
							// leading edge only samples, so the data line holds here
							samp_q <= in_s2_q;
						end else begin
							// trailing edge: msb moves out, sampled bit into lsb
							shift_q <= {shift_q[DATA_W-2:0], samp_q};
							if (bit_q == SSP_BIT_CNT_W'(DATA_W-1)) begin
								state_q <= SSP_DONE;
							end else begin
								bit_q <= bit_q + 1'b1;
							end
						end
					end
				end
				SSP_SEQ: begin
					// two half periods per condition, data moves while clock high
					if (tick) begin
						seq_ph_q <= ~seq_ph_q;
						case (seq_q)
							SSP_SEQ_START: begin
								if (!seq_ph_q) begin
									sda_q <= 1'b0;
								end else begin
									scl_q <= 1'b0;
									state_q <= SSP_DONE;
								end
							end
							SSP_SEQ_RESTART: begin
								if (!seq_ph_q) begin
									sda_q <= 1'b1;
									scl_q <= 1'b1;
								end else begin
									sda_q <= 1'b0;
									state_q <= SSP_DONE;
								end
							end
							default: begin
								if (!seq_ph_q) begin
									sda_q <= 1'b0;
									scl_q <= 1'b1;
								end else begin
									sda_q <= 1'b1;
									state_q <= SSP_DONE;
								end
							end
						endcase
					end
				end
				default: begin
					// clock pin keeps its last level, select released when nothing queued
					if (seq_q == SSP_SEQ_NONE && !tx_valid_i) begin
						ss_n_q <= 1'b1;
					end
					seq_q <= SSP_SEQ_NONE;
					state_q <= SSP_IDLE;
				end
			endcase
		end
	end

	// receive buffer push at byte end
	assign buf_push = (state_q == SSP_DONE) && (seq_q == SSP_SEQ_NONE);
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			buf_cnt_q <= 2'd0;
			buf_q[0] <= '0;
			buf_q[1] <= '0;
		end else begin
			if (buf_push) begin
				buf_q[wr_ptr_q] <= shift_q;
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (buf_pop) begin
				rd_ptr_q <= ~rd_ptr_q;
			end
			buf_cnt_q <= buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};
		end
	end

	// done pulse
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			serial_done_flag_o <= 1'b0;
		end else begin
			serial_done_flag_o <= (state_q == SSP_DONE);
		end
	end

	// msb drives the data line, changes on trailing edge
	assign link.serial_out_pin_m = shift_q[DATA_W-1];
	assign link.serial_clock_pin = sck_q;
	assign link.slave_select_n = ss_n_q;
	assign link.two_wire_data_pin = sda_q;
	assign link.two_wire_clock_pin = scl_q;
endmodule
`default_nettype wire

// File: hw/ssp_pkg.sv
// ssp_pkg: shared constants for the synchronous serial port ends
package ssp_pkg;
	localparam int SSP_DATA_W = 8;
	localparam int SSP_BIT_CNT_W = 3;
	localparam logic [7:0] SSP_RELOAD_RST = 8'h04;
	localparam logic [7:0] SSP_CTRL2_RST = 8'h00;
	// serial_control_two field positions
	localparam int SSP_START_BIT = 0;
	localparam int SSP_RESTART_BIT = 1;
	localparam int SSP_STOP_BIT = 2;
	// serial clock divider: one reload per half period, fsck = fosc / (4 * (reload + 1))
	localparam int SSP_HALF_MULT = 2;
	// two-wire sequence phases: each condition takes this many rate_counter rollovers
	localparam int SSP_SEQ_PHASES = 2;
	typedef enum logic [3:0] {
		SSP_IDLE = 4'b0001,
		SSP_SHIFT = 4'b0010,
		SSP_SEQ = 4'b0100,
		SSP_DONE = 4'b1000
	} ssp_state_t;
	typedef enum logic [1:0] {
		SSP_SEQ_NONE = 2'h0,
		SSP_SEQ_START = 2'h1,
		SSP_SEQ_RESTART = 2'h2,
		SSP_SEQ_STOP = 2'h3
	} ssp_seq_t;
endpackage

// File: hw/ssp_slave.sv
// ssp_slave: spi slave end with eight-bit shift register
`timescale 1ns/1ps
`default_nettype none
module ssp_slave
	import ssp_pkg::*;
#(
	parameter int DATA_W = SSP_DATA_W
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic clock_idle_polarity_i,
	input wire logic [DATA_W-1:0] tx_data_i,
	input wire logic tx_load_i,
	output logic [DATA_W-1:0] rx_data_o,
	output logic rx_valid_o,
	ssp_link_if.slave link
);
	logic sck_s1_q, sck_s2_q, sck_s3_q;
	logic ss_s1_q, ss_s2_q;
	logic din_s1_q, din_s2_q;
	logic [DATA_W-1:0] shift_q;
	logic samp_q;
	logic [SSP_BIT_CNT_W-1:0] bit_q;
	logic lead_edge;
	logic trail_edge;
	logic sel;

	// pins come from the master's domain, two flops each, plus a third on the clock for edge detection
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sck_s1_q <= 1'b0;
			sck_s2_q <= 1'b0;
			sck_s3_q <= 1'b0;
			ss_s1_q <= 1'b1;
			ss_s2_q <= 1'b1;
			din_s1_q <= 1'b0;
			din_s2_q <= 1'b0;
		end else begin
			sck_s1_q <= link.serial_clock_pin;
			sck_s2_q <= sck_s1_q;
			sck_s3_q <= sck_s2_q;
			ss_s1_q <= link.slave_select_n;
			ss_s2_q <= ss_s1_q;
			din_s1_q <= link.serial_out_pin_m;
			din_s2_q <= din_s1_q;
		end
	end

	assign sel = !ss_s2_q;
	// leading edge leaves the idle level, same polarity as the master
	assign lead_edge = (sck_s3_q == clock_idle_polarity_i) && (sck_s2_q != clock_idle_polarity_i);
	assign trail_edge = (sck_s3_q != clock_idle_polarity_i) && (sck_s2_q == clock_idle_polarity_i);

	// shift only while selected; unselected ignores clock and data
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shift_q <= '0;
			samp_q <= 1'b0;
			bit_q <= '0;
			rx_valid_o <= 1'b0;
			rx_data_o <= '0;
		end else begin
			rx_valid_o <= 1'b0;
			if (!sel) begin
				bit_q <= '0;
				if (tx_load_i) begin
					shift_q <= tx_data_i;
				end
			end else if (lead_edge) begin
				// sample only; the output bit must hold until the trailing edge
				samp_q <= din_s2_q;
			end else if (trail_edge) begin
				bit_q <= bit_q + 1'b1;
				shift_q <= {shift_q[DATA_W-2:0], samp_q};
				if (bit_q == SSP_BIT_CNT_W'(DATA_W-1)) begin
					rx_data_o <= {shift_q[DATA_W-2:0], samp_q};
					rx_valid_o <= 1'b1;
					if (tx_load_i) begin
						shift_q <= tx_data_i;
					end
				end
			end
		end
	end

	// output released when not selected
	assign link.serial_out_pin_s = shift_q[DATA_W-1];
	assign link.serial_out_oe_n_s = !sel;
endmodule
`default_nettype wire
